/* File: rtl/poc_ctrl.sv */
// Purpose: offset calibration registers, sleep gating and offset search
// Assumes: two-wire slave clock well below mclk_i; engine on mclk_i
// Notes: measurement engine is outside; it reports results and events
// Functional notes
// - Trim register resets to 0x2A; host writes 0x29 before use.
// - With read-clear set, reading status clears all status flags.
// - Oscillator off without power-on; sleep mode gates it by interrupt.
// - Cycle end with enabled light or near flag pending and sleep mode halts oscillator.
// - While halted, power-on still reads back as one.
// - Clearing pending status flags or their interrupt enables restarts a halted oscillator.
// - Pulse control bit six: one disables automatic pulse control.
// - Reserved fields reset to 0001 and 111111 respectively.
// - Offset magnitude is eight bits, resets zero, host writable.
// - Offset sign in bit zero; upper seven bits reserved, zero.
// - Sign-magnitude offset up to 255 applied to front end result.
// - Calibration bit seven enables averaging of samples.
// - Calibration bit five selects electrical-only crosstalk calibration.
// - Electrical-only calibration disconnects the photodiode; same procedure.
// - Calibration bit four applies sample wait between averaging samples.
// - Writing one to calibration bit zero starts the sequence.
// - Search adjusts offset until result is nearest the target.
// - Calibration-complete flag sets when the sequence finishes.
// - Finished search loads offset sign and magnitude registers.
// - Three-bit target code selects 3 to 511, default code 2.
// - Pulse control off: 10-bit result, upper eight bits compared.
`timescale 1ns/1ps
`default_nettype none
module poc_ctrl (
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // two-wire slave pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // interrupt pin and oscillator gate
    output logic irq_n_o,
    output logic osc_en_o,
    // measurement engine events
    input wire logic cycle_done_i,
    input wire logic light_irq_set_i,
    input wire logic near_irq_set_i,
    input wire logic meas_done_i,
    input wire logic [13:0] near_result_i,
    // front end control
    output logic cal_meas_req_o,
    output logic cal_active_o,
    output logic pd_disconnect_o,
    output logic offset_calibration_control_avg_en_o,
    output logic offset_calibration_control_wait_apply_o,
    output logic pulse_ctrl_off_o,
    output logic [7:0] trim_o,
    output poc_pkg::poc_offset_s offset_o,
    output logic [13:0] near_cmp_o
);
    import poc_pkg::*;

    logic scl_s1_r, scl_s2_r, scl_s3_r;
    logic sda_s1_r, sda_s2_r, sda_s3_r;
    logic scl_rise, scl_fall, i2c_start, i2c_stop;
    poc_i2c_e ist_r;
    logic [7:0] sh_r, ptr_r, tx_r;
    logic [3:0] bcnt_r;
    logic [1:0] phase_r;
    logic rw_r, nack_r;
    logic wr_stb_r, rd_stb_r;
    logic [7:0] wr_addr_r, wr_data_r, rd_addr_r;
    logic [7:0] enab_r, trim_r, irqb_r, pulse_r, ofsm_r, ofss_r, cal_r;
    logic [7:0] calcfg_r;
    logic [2:0] stat_r, stat_clr, stat_set;
    logic halted_r, pend, pin_pend, sda_drv_r;
    poc_cal_e cst_r;
    logic [8:0] sar_r;
    logic [3:0] bidx_r;
    logic [15:0] acc_r, acc_sum, avg;
    logic [CAL_AVG_LOG2-1:0] cnt_r;
    logic cal_go, cal_fin;
    poc_offset_s cal_res;

    function automatic logic [7:0] rd_mux(input logic [7:0] a);
        case (a)
            A_ENAB: rd_mux = enab_r;
            A_STAT: rd_mux = {5'h00, stat_r};
            A_TRIM: rd_mux = trim_r;
            A_IRQB: rd_mux = irqb_r;
            A_PULSE: rd_mux = pulse_r;
            A_OFSM: rd_mux = ofsm_r;
            A_OFSS: rd_mux = ofss_r;
            A_CAL: rd_mux = cal_r;
            A_CALCFG: rd_mux = calcfg_r;
            default: rd_mux = R_ZERO;
        endcase
    endfunction

    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = wr_stb_r && (wr_addr_r == a);
    endfunction

    // first bit on the wire; a select on a call is not legal
    function automatic logic rd_msb(input logic [7:0] a);
        logic [7:0] v;
        v = rd_mux(a);
        return v[7];
    endfunction

    // pin synchronisers; stage three only feeds edge detection
    always_ff @(posedge mclk_i)
    begin
        scl_s1_r <= scl_i;
        scl_s2_r <= scl_s1_r;
        scl_s3_r <= scl_s2_r;
        sda_s1_r <= sda_i;
        sda_s2_r <= sda_s1_r;
        sda_s3_r <= sda_s2_r;
    end

    assign scl_rise = scl_s2_r && !scl_s3_r;
    assign scl_fall = !scl_s2_r && scl_s3_r;
    assign i2c_start = scl_s2_r && scl_s3_r && sda_s3_r && !sda_s2_r;
    assign i2c_stop = scl_s2_r && scl_s3_r && !sda_s3_r && sda_s2_r;

    // two-wire slave: phase 0 address, 1 pointer, 2 data
    always_ff @(posedge mclk_i)
    begin
        wr_stb_r <= 1'b0;
        rd_stb_r <= 1'b0;
        if (!resetn_i)
        begin
            ist_r <= I_IDLE;
            sh_r <= R_ZERO;
            tx_r <= R_ZERO;
            ptr_r <= R_ZERO;
            bcnt_r <= 4'h0;
            phase_r <= 2'd0;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            sda_oe_o <= 1'b0;
            wr_addr_r <= R_ZERO;
            wr_data_r <= R_ZERO;
            rd_addr_r <= R_ZERO;
        end
        else if (i2c_start)
        begin
            ist_r <= I_RX;
            bcnt_r <= 4'h0;
            phase_r <= 2'd0;
            sda_oe_o <= 1'b0;
        end
        else if (i2c_stop)
        begin
            ist_r <= I_IDLE;
            sda_oe_o <= 1'b0;
        end
        else
        begin
            case (ist_r)
                I_RX:
                begin
                    if (scl_rise)
                    begin
                        sh_r <= {sh_r[6:0], sda_s2_r};
                        bcnt_r <= bcnt_r + 4'h1;
                    end
                    else if (scl_fall && bcnt_r == BITS_BYTE)
                    begin
                        ist_r <= I_ACK;
                        sda_oe_o <= 1'b1;
                        if (phase_r == 2'd0)
                        begin
                            rw_r <= sh_r[0];
                            phase_r <= 2'd1;
                            if (sh_r[7:1] != DEV_ADDR)
                            begin
                                ist_r <= I_IDLE;
                                sda_oe_o <= 1'b0;
                            end
                        end
                        else if (phase_r == 2'd1)
                        begin
                            ptr_r <= sh_r;
                            phase_r <= 2'd2;
                        end
                        else
                        begin
                            wr_stb_r <= 1'b1;
                            wr_addr_r <= ptr_r;
                            wr_data_r <= sh_r;
                            ptr_r <= ptr_r + 8'h01;
                        end
                    end
                end
                I_ACK:
                begin
                    if (scl_fall)
                    begin
                        bcnt_r <= 4'h0;
                        if (rw_r)
                        begin
                            ist_r <= I_TX;
                            tx_r <= rd_mux(ptr_r);
                            sda_oe_o <= !rd_msb(ptr_r);
                            rd_stb_r <= 1'b1;
                            rd_addr_r <= ptr_r;
                            ptr_r <= ptr_r + 8'h01;
                        end
                        else
                        begin
                            ist_r <= I_RX;
                            sda_oe_o <= 1'b0;
                        end
                    end
                end
                I_TX:
                begin
                    if (scl_fall)
                    begin
                        bcnt_r <= bcnt_r + 4'h1;
                        tx_r <= {tx_r[6:0], 1'b0};
                        sda_oe_o <= !tx_r[6];
                        if (bcnt_r == BITS_LAST)
                        begin
                            ist_r <= I_MACK;
                            sda_oe_o <= 1'b0;
                        end
                    end
                end
                I_MACK:
                begin
                    if (scl_rise)
                        nack_r <= sda_s2_r;
                    // master ack: next byte leaves on this same fall
                    else if (scl_fall && !nack_r)
                    begin
                        ist_r <= I_TX;
                        bcnt_r <= 4'h0;
                        tx_r <= rd_mux(ptr_r);
                        sda_oe_o <= !rd_msb(ptr_r);
                        rd_stb_r <= 1'b1;
                        rd_addr_r <= ptr_r;
                        ptr_r <= ptr_r + 8'h01;
                    end
                    else if (scl_fall)
                        ist_r <= I_IDLE;
                end
                default:
                begin
                    ist_r <= I_IDLE;
                    sda_oe_o <= 1'b0;
                end
            endcase
        end
    end

    // open-drain: only ever pull low
    always_ff @(posedge mclk_i)
    begin
        sda_drv_r <= 1'b0;
        sda_o <= sda_drv_r;
    end

    // configuration registers
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            enab_r <= R_ZERO;
            trim_r <= R_TRIM;
            irqb_r <= R_IRQB;
            pulse_r <= R_PULSE;
            ofsm_r <= R_ZERO;
            ofss_r <= R_ZERO;
            calcfg_r <= R_CALCFG;
        end
        else
        begin
            if (wr_hit(A_ENAB))
                enab_r <= wr_data_r;
            if (wr_hit(A_TRIM))
                trim_r <= wr_data_r;
            if (wr_hit(A_IRQB))
                irqb_r <= wr_data_r;
            if (wr_hit(A_PULSE))
                pulse_r <= wr_data_r;
            if (wr_hit(A_CALCFG))
                calcfg_r <= wr_data_r;
            // search result overrides a host write
            if (cal_fin)
            begin
                ofsm_r <= cal_res.magnitude;
                ofss_r <= {7'h00, cal_res.sign};
            end
            else
            begin
                if (wr_hit(A_OFSM))
                    ofsm_r <= wr_data_r;
                if (wr_hit(A_OFSS))
                    ofss_r <= wr_data_r;
            end
        end
    end

    // start bit launches search, any type
    assign cal_go = wr_stb_r && wr_addr_r == A_CAL && wr_data_r[B_START]
        && cst_r == C_IDLE;
    assign cal_fin = (cst_r == C_DONE);
    assign cal_res = poc_to_sm(sar_r);

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
            cal_r <= R_ZERO;
        else if (cal_fin)
            cal_r[B_START] <= 1'b0;
        else if (wr_hit(A_CAL))
            cal_r <= wr_data_r;
    end

    // status flags: set wins over clear
    always_comb
    begin
        stat_clr = 3'h0;
        if (wr_hit(A_STAT))
            stat_clr = wr_data_r[2:0];
        if (rd_stb_r && rd_addr_r == A_STAT && irqb_r[B_RDCLR])
            stat_clr = 3'h7;
        stat_set = 3'h0;
        stat_set[B_LFLG] = light_irq_set_i;
        stat_set[B_NFLG] = near_irq_set_i;
        stat_set[B_CFLG] = cal_fin;
    end

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
            stat_r <= 3'h0;
        else
            stat_r <= (stat_r & ~stat_clr) | stat_set;
    end

    assign pend = (stat_r[B_LFLG] && enab_r[B_LIEN])
        || (stat_r[B_NFLG] && enab_r[B_NIEN]);
    assign pin_pend = pend || (stat_r[B_CFLG] && enab_r[B_CIEN]);

    // halt latch; released when pend drops or power-on is cleared
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i || !enab_r[B_PON])
            halted_r <= 1'b0;
        else if (cycle_done_i && irqb_r[B_SAI] && pend)
            halted_r <= 1'b1;
        else if (!pend)
            halted_r <= 1'b0;
    end

    // gate oscillator; power-on bit itself untouched
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            osc_en_o <= 1'b0;
            irq_n_o <= 1'b1;
        end
        else
        begin
            osc_en_o <= enab_r[B_PON] && !halted_r;
            irq_n_o <= !pin_pend;
        end
    end

    assign acc_sum = acc_r + {2'b00, near_result_i};
    assign avg = cal_r[B_CAVG] ? (acc_r >> CAL_AVG_LOG2) : acc_r;

    always_ff @(posedge mclk_i)
    begin
        cal_meas_req_o <= 1'b0;
        if (!resetn_i)
        begin
            cst_r <= C_IDLE;
            sar_r <= SAR_MID;
            bidx_r <= SAR_MSB;
            acc_r <= 16'h0000;
            cnt_r <= '0;
        end
        else
        begin
            case (cst_r)
                C_IDLE:
                    if (cal_go)
                    begin
                        sar_r <= SAR_MID;
                        bidx_r <= SAR_MSB;
                        cst_r <= C_SET;
                    end
                C_SET:
                begin
                    acc_r <= 16'h0000;
                    cnt_r <= '0;
                    cal_meas_req_o <= 1'b1;
                    cst_r <= C_MEAS;
                end
                C_MEAS:
                    if (meas_done_i)
                    begin
                        acc_r <= acc_sum;
                        cnt_r <= cnt_r + 1'b1;
                        if (cal_r[B_CAVG] && cnt_r != CAL_AVG_LAST)
                            cal_meas_req_o <= 1'b1;
                        else
                            cst_r <= C_JUDGE;
                    end
                C_JUDGE:
                begin
                    // target from code; too little offset keeps bit
                    if (avg <= {6'h00,
                        poc_target(calcfg_r[F_TGT_HI:F_TGT_LO])})
                        sar_r[bidx_r] <= 1'b0;
                    if (bidx_r == 4'h0)
                        cst_r <= C_DONE;
                    else
                    begin
                        sar_r[bidx_r - 4'h1] <= 1'b1;
                        bidx_r <= bidx_r - 4'h1;
                        cst_r <= C_SET;
                    end
                end
                C_DONE:
                    cst_r <= C_IDLE;
                default:
                    cst_r <= C_IDLE;
            endcase
        end
    end

    // front end controls, all registered
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            cal_active_o <= 1'b0;
            pd_disconnect_o <= 1'b0;
            offset_calibration_control_avg_en_o <= 1'b0;
            offset_calibration_control_wait_apply_o <= 1'b0;
            pulse_ctrl_off_o <= 1'b0;
            trim_o <= R_TRIM;
            offset_o <= '0;
            near_cmp_o <= 14'h0000;
        end
        else
        begin
            cal_active_o <= (cst_r != C_IDLE);
            pd_disconnect_o <= (cst_r != C_IDLE) && cal_r[B_ELEC];
            offset_calibration_control_avg_en_o <= cal_r[B_CAVG];
            offset_calibration_control_wait_apply_o <= cal_r[B_CWAIT];
            pulse_ctrl_off_o <= pulse_r[B_PCOFF];
            trim_o <= trim_r;
            // offset to front end; trial value while searching
            if (cst_r != C_IDLE)
                offset_o <= cal_res;
            else
                offset_o <= '{sign: ofss_r[B_SIGN], magnitude: ofsm_r};
            if (pulse_r[B_PCOFF])
                near_cmp_o <= {6'h00, near_result_i[9:2]};
            else
                near_cmp_o <= near_result_i;
        end
    end
endmodule
`default_nettype wire

/* File: include/poc_pkg.sv */
// Purpose: constants and types for the proximity offset calibration block
// Assumes: 8-bit register map reached over a two-wire slave port
// Notes: status, enable and search-config layouts are local choices
`default_nettype none
package poc_pkg;
    // register addresses
    localparam logic [7:0] A_ENAB = 8'h80;
    localparam logic [7:0] A_STAT = 8'h9B;
    localparam logic [7:0] A_TRIM = 8'hAA;
    localparam logic [7:0] A_IRQB = 8'hAB;
    localparam logic [7:0] A_PULSE = 8'hAE;
    localparam logic [7:0] A_OFSM = 8'hC0;
    localparam logic [7:0] A_OFSS = 8'hC1;
    localparam logic [7:0] A_CAL = 8'hD7;
    localparam logic [7:0] A_CALCFG = 8'hD9;
    // reset values
    localparam logic [7:0] R_ZERO = 8'h00;
    localparam logic [7:0] R_TRIM = 8'h2A;
    localparam logic [7:0] R_IRQB = 8'h01;
    localparam logic [7:0] R_PULSE = 8'h3F;
    localparam logic [7:0] R_CALCFG = 8'h50;
    // bit positions
    localparam int B_RDCLR = 7;
    localparam int B_SAI = 4;
    localparam int B_PCOFF = 6;
    localparam int B_SIGN = 0;
    localparam int B_CAVG = 7;
    localparam int B_ELEC = 5;
    localparam int B_CWAIT = 4;
    localparam int B_START = 0;
    localparam int B_PON = 0;
    localparam int B_LIEN = 1;
    localparam int B_NIEN = 2;
    localparam int B_CIEN = 3;
    localparam int B_LFLG = 0;
    localparam int B_NFLG = 1;
    localparam int B_CFLG = 2;
    localparam int F_TGT_HI = 7;
    localparam int F_TGT_LO = 5;
    // slave address: arbitrary value
    localparam logic [6:0] DEV_ADDR = 7'h2C;
    // averaging depth as a power of two during calibration
    localparam int CAL_AVG_LOG2 = 2;
    localparam logic [CAL_AVG_LOG2-1:0] CAL_AVG_LAST = '1;
    localparam logic [3:0] SAR_MSB = 4'h8;
    localparam logic [8:0] SAR_MID = 9'h100;
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam logic [3:0] BITS_LAST = 4'h7;

    typedef struct packed {
        logic sign;
        logic [7:0] magnitude;
    } poc_offset_s;

    typedef enum logic [2:0] {
        I_IDLE = 3'b000,
        I_RX = 3'b001,
        I_ACK = 3'b011,
        I_TX = 3'b010,
        I_MACK = 3'b110
    } poc_i2c_e;

    typedef enum logic [2:0] {
        C_IDLE = 3'b000,
        C_SET = 3'b001,
        C_MEAS = 3'b011,
        C_JUDGE = 3'b010,
        C_DONE = 3'b110
    } poc_cal_e;

    function automatic logic [9:0] poc_target(input logic [2:0] sel);
        logic [10:0] t;
        t = (11'h004 << sel) - 11'h001;
        return t[9:0];
    endfunction

    // search code u stands for offset u-256, magnitude clamped at 255
    function automatic poc_offset_s poc_to_sm(input logic [8:0] u);
        poc_offset_s o;
        logic [8:0] d;
        d = SAR_MID - u;
        o.sign = ~u[8];
        if (u[8])
            o.magnitude = u[7:0];
        else if (u == 9'h000)
            o.magnitude = 8'hFF;
        else
            o.magnitude = d[7:0];
        return o;
    endfunction
endpackage
`default_nettype wire

/* File: test/poc_host_model.sv */
// Purpose: two-wire bus master driving the slave pins
// Assumes: open-drain data line with pull-up, 125 ns bus clock
// Notes: each read byte shows as a short strobe on rd_v
`timescale 1ns/1ps
`default_nettype none
module poc_host_model
    import poc_pkg::*;
(
    // bus pins
    input wire logic sda_oe_i,
    output logic scl_o,
    output logic sda_o,
    // read result
    output logic rd_v,
    output logic [7:0] rd_d
);
    localparam realtime Q = 31.25;
    logic pull;
    // released line floats high through the pull-up
    assign sda_o = ~(pull | (sda_oe_i === 1'b1));
    initial
    begin
        scl_o = 1'b1;
        pull = 1'b0;
        rd_v = 1'b0;
        rd_d = 8'h00;
    end
    task automatic start();
        pull = 1'b0;
        #Q scl_o = 1'b1;
        #Q pull = 1'b1;
        #Q scl_o = 1'b0;
        #Q;
    endtask
    task automatic stop();
        pull = 1'b1;
        #Q scl_o = 1'b1;
        #Q pull = 1'b0;
        #Q;
    endtask
    task automatic xfer(input logic [7:0] d, input logic l,
                        output logic [7:0] q);
        for (int i = 8; i >= 0; i--)
        begin
            pull = (i == 0) ? ~l : ~d[i-1];
            #Q scl_o = 1'b1;
            #Q if (i > 0) q[i-1] = sda_o;
            #Q scl_o = 1'b0;
            #Q;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, q);
        xfer(a, 1'b1, q);
        xfer(d, 1'b1, q);
        stop();
    endtask
    task automatic rd(input logic [7:0] a);
        logic [7:0] q;
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, q);
        xfer(a, 1'b1, q);
        start();
        xfer({DEV_ADDR, 1'b1}, 1'b1, q);
        xfer(8'hFF, 1'b1, q);
        stop();
        rd_d = q;
        rd_v = 1'b1;
        #5 rd_v = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: test/poc_ctrl_checker.sv */
// Purpose: port-level assertions for the offset calibration block
// Assumes: single mclk_i domain, synchronous active-low reset
// Notes: step counter only counts while calibration is running
`timescale 1ns/1ps
`default_nettype none
module poc_ctrl_checker (
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // watched signals
    input wire logic irq_n_o,
    input wire logic osc_en_o,
    input wire logic meas_done_i,
    input wire logic [13:0] near_result_i,
    input wire logic cal_meas_req_o,
    input wire logic cal_active_o,
    input wire logic pd_disconnect_o,
    input wire logic offset_calibration_control_avg_en_o,
    input wire logic pulse_ctrl_off_o,
    input wire logic [7:0] trim_o,
    input wire logic [13:0] near_cmp_o
);
    logic [5:0] req_cnt_r;
    default clocking cb @(posedge mclk_i);
    endclocking
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i || !cal_active_o)
            req_cnt_r <= 6'h00;
        else if (cal_meas_req_o)
            req_cnt_r <= req_cnt_r + 6'h01;
    end
    trim_reset_a: assert property (!resetn_i |=> trim_o == 8'h2A)
        else $error("trim output not at reset value");
    idle_reset_a: assert property (!resetn_i |=>
        irq_n_o && !osc_en_o && !pulse_ctrl_off_o)
        else $error("outputs not idle after reset");
    cmp_track_a: assert property (disable iff (!resetn_i)
        $past(resetn_i) |-> near_cmp_o == (pulse_ctrl_off_o ?
        {6'h00, $past(near_result_i[9:2])} : $past(near_result_i)))
        else $error("compare value does not follow result");
    req_in_cal_a: assert property (disable iff (!resetn_i)
        cal_meas_req_o |-> cal_active_o)
        else $error("measurement request outside calibration");
    req_pulse_a: assert property (disable iff (!resetn_i)
        cal_meas_req_o |=> !cal_meas_req_o)
        else $error("measurement request longer than one cycle");
    step_count_a: assert property (disable iff (!resetn_i)
        $fell(cal_active_o) |->
        req_cnt_r == (offset_calibration_control_avg_en_o ? 6'h24 : 6'h09))
        else $error("wrong number of search measurements");
    pd_in_cal_a: assert property (disable iff (!resetn_i)
        pd_disconnect_o |-> cal_active_o || $past(cal_active_o))
        else $error("photodiode cut outside calibration");
    step_advance_a: assert property (disable iff (!resetn_i)
        cal_active_o && meas_done_i |->
        ##[1:8] (cal_meas_req_o || !cal_active_o))
        else $error("search stalled after a result");
endmodule
bind poc_ctrl poc_ctrl_checker chk_u (
    .mclk_i, .resetn_i, .irq_n_o, .osc_en_o, .meas_done_i,
    .near_result_i, .cal_meas_req_o, .cal_active_o, .pd_disconnect_o,
    .offset_calibration_control_avg_en_o, .pulse_ctrl_off_o, .trim_o, .near_cmp_o
);
`default_nettype wire

/* File: test/prox_offset_calibration_ctrl_test.sv */
// Purpose: self-checking bench for the offset calibration block
// Assumes: host model on the bus pins, bench as measurement engine
// Notes: crosstalk model subtracts the signed offset from a base
`timescale 1ns/1ps
`default_nettype none
module prox_offset_calibration_ctrl_test;
    import poc_pkg::*;
    logic mclk_i;
    logic resetn_i;
    logic scl_i, sda_i, sda_o, sda_oe_o, irq_n_o, osc_en_o;
    logic meas_done_i, cal_meas_req_o, cal_active_o, pd_disconnect_o;
    logic offset_calibration_control_avg_en_o, offset_calibration_control_wait_apply_o, pulse_ctrl_off_o;
    logic rd_v;
    logic [7:0] rd_d, trim_o, m;
    logic [2:0] ev;
    logic [13:0] near_result_i, near_cmp_o;
    poc_offset_s offset_o;
    logic [7:0] expq[$];
    int n_errors = 0;
    int samples_checked = 0;
    int xt = 0;
    int dly = 0;
    int rs = 0;
    logic [7:0] ra [7] = '{A_TRIM, A_IRQB, A_PULSE, A_OFSM, A_OFSS,
                           A_CAL, A_CALCFG};
    logic [7:0] rv [7] = '{8'h2A, 8'h01, 8'h3F, 8'h00, 8'h00, 8'h00,
                           8'h50};
    poc_ctrl dut_u (.mclk_i, .resetn_i, .scl_i, .sda_i, .sda_o,
        .sda_oe_o, .irq_n_o, .osc_en_o, .cycle_done_i(ev[2]),
        .light_irq_set_i(ev[1]), .near_irq_set_i(ev[0]), .meas_done_i,
        .near_result_i, .cal_meas_req_o, .cal_active_o,
        .pd_disconnect_o, .offset_calibration_control_avg_en_o, .offset_calibration_control_wait_apply_o,
        .pulse_ctrl_off_o, .trim_o, .offset_o, .near_cmp_o);
    // line is pulled only when the drive value is low
    poc_host_model host_u (.sda_oe_i(sda_oe_o & ~sda_o), .scl_o(scl_i),
        .sda_o(sda_i), .rd_v, .rd_d);
    initial mclk_i = 1'b0;
    always #2.5 mclk_i = ~mclk_i;
    task automatic tally_and_finish();
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(input logic [8:0] g, input logic [8:0] e);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        host_u.rd(a);
    endtask
    always @(posedge rd_v)
        cmp(9'(rd_d), 9'(expq.pop_front()));
    // model result driven while a request is pending, strobed on its last cycle; noise otherwise
    always @(negedge mclk_i)
    begin
        meas_done_i <= 1'b0;
        near_result_i <= 14'($urandom);
        if (cal_meas_req_o)
            dly = $urandom_range(12, 1);
        else if (dly > 0)
        begin
            dly = dly - 1;
            meas_done_i <= (dly == 0);
            // the front end floors an over-cancelled result at zero
            rs = xt - (offset_o.sign ?
                -int'(offset_o.magnitude) : int'(offset_o.magnitude));
            near_result_i <= 14'(rs < 0 ? 0 : rs);
        end
    end
    task automatic ev_pulse(input logic [2:0] v);
        @(negedge mclk_i) ev <= v;
        @(negedge mclk_i) ev <= 3'b000;
        repeat (3) @(negedge mclk_i);
    endtask
    task automatic offset_calibration_control(input logic [7:0] ctl);
        int u;
        logic [2:0] code;
        code = 3'($urandom_range(4, 0));
        xt = $urandom_range(255, 0);
        u = xt + 255 - ((4 << code) - 1);
        host_u.wr(A_CALCFG, {code, 5'h10});
        host_u.wr(A_CAL, ctl);
        if (ctl[7])
            cmp({cal_active_o, 7'h00, pd_disconnect_o}, 9'h101);
        for (int i = 0; i < 4000 && cal_active_o === 1'b1; i++)
            @(negedge mclk_i);
        if (cal_active_o !== 1'b0)
        begin
            n_errors++;
            tally_and_finish();
        end
        rd_chk(A_OFSM, 8'(u < 256 ? 256 - u : u - 256));
        rd_chk(A_OFSS, 8'(u < 256));
        rd_chk(A_CAL, ctl & 8'hFE);
    endtask
    initial
    begin
        void'($urandom(34845));
        ev = 3'b000;
        resetn_i = 1'b0;
        repeat (5) @(negedge mclk_i);
        resetn_i <= 1'b1;
        repeat (4) @(negedge mclk_i);
        for (int i = 0; i < 7; i++)
            rd_chk(ra[i], rv[i]);
        host_u.wr(A_TRIM, 8'h29);
        rd_chk(A_TRIM, 8'h29);
        cmp(9'(trim_o), 9'h029);
        m = 8'($urandom);
        host_u.wr(A_OFSM, m);
        host_u.wr(A_OFSS, 8'h01);
        cmp(offset_o, {1'b1, m});
        rd_chk(A_OFSM, m);
        rd_chk(A_OFSS, 8'h01);
        offset_calibration_control(8'h11);
        cmp(9'(offset_calibration_control_wait_apply_o), 9'h001);
        rd_chk(A_STAT, 8'h04);
        rd_chk(A_STAT, 8'h04);
        host_u.wr(A_STAT, 8'h04);
        host_u.wr(A_IRQB, 8'h81);
        offset_calibration_control(8'hA1);
        cmp(9'(offset_calibration_control_avg_en_o), 9'h001);
        ev_pulse(3'b001);
        rd_chk(A_STAT, 8'h06);
        rd_chk(A_STAT, 8'h00);
        host_u.wr(A_ENAB, 8'h03);
        host_u.wr(A_IRQB, 8'h11);
        cmp(9'(osc_en_o), 9'h001);
        ev_pulse(3'b010);
        ev_pulse(3'b100);
        cmp({irq_n_o, osc_en_o}, 9'h000);
        rd_chk(A_ENAB, 8'h03);
        ev_pulse(3'b100);
        cmp(9'(osc_en_o), 9'h000);
        host_u.wr(A_STAT, 8'h01);
        repeat (4) @(negedge mclk_i);
        cmp(9'(osc_en_o), 9'h001);
        host_u.wr(A_PULSE, 8'h7F);
        cmp(9'(pulse_ctrl_off_o), 9'h001);
        rd_chk(8'h50, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
